// [common/vbt_regs.vh]
// constants for the video buffer line timing block: register offsets,
// reset values, segment counts and output patterns
// assumes a 200 MHz core clock that also serves as the pixel step clock
`ifndef VBT_REGS_VH
`define VBT_REGS_VH

// register offsets (byte addresses, one 32-bit word each)
`define VBT_OFF_CTRL      8'h00
`define VBT_OFF_A_LINES   8'h04
`define VBT_OFF_B_LINES   8'h08
`define VBT_OFF_D_LINES   8'h0c
`define VBT_OFF_STATUS    8'h10

// control register fields and reset values
`define VBT_CTRL_EN_BIT   0
`define VBT_CTRL_RST      1'h0
`define VBT_A_LINES_RST   10'h002
`define VBT_B_LINES_RST   10'h020
`define VBT_D_LINES_RST   10'h00b

// status register field positions
`define VBT_ST_LINE_LSB   0
`define VBT_ST_PERIOD_LSB 16
`define VBT_ST_UPPER_BIT  20

// display period line structure
`define VBT_DISP_LINES    10'h200
`define VBT_LOOP_LINES    10'h080
`define VBT_HALF_LINES    10'h100

// loop counter reload values per segment
`define VBT_LD_FIRST      8'd18
`define VBT_LD_SHORT      8'd19
`define VBT_LD_CHUNK      8'h7f
`define VBT_LD_END        8'h00

// segment output patterns
`define VBT_PAT_C0        6'h33
`define VBT_PAT_C1        6'h13
`define VBT_PAT_C2        6'h11
`define VBT_PAT_C3        6'h08
`define VBT_PAT_C4        6'h11
`define VBT_PAT_PIX_BIT   3

// refresh spacing guard
`define VBT_CLK_MHZ       200
`define VBT_REFR_MAX_NS   15600
`define VBT_REFR_MAX_CYC  ((`VBT_REFR_MAX_NS * `VBT_CLK_MHZ) / 1000)
// guard counts 0..last then fires, one request per 3120 cycles; it
// starts two counts in to cover the two cycles of the reset synchroniser
`define VBT_REFR_GUARD_LAST 12'hc2f
`define VBT_GUARD_RST       12'h002

`endif

// [rtl/vbt_line_timing.v]
// video buffer line timing generator: per-line segment sequencer, frame
// period sequencer, quadrant output enables, shift clock gate, refresh and
// transfer requests, and a small register port
// assumes CORE_CLK is the pixel step clock and the memory controller
// arbitrates the refresh and transfer requests it receives
`timescale 1ns/1ps
`include "vbt_regs.vh"

module vbt_line_timing (
  // clock and reset
  CORE_CLK,
  NRST,
  // register port
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  // video memory serial side
  SHIFT_CLOCK_EN,
  UPPER_LEFT_OE,
  UPPER_RIGHT_OE,
  LOWER_LEFT_OE,
  LOWER_RIGHT_OE,
  VSYNC,
  CTRL_PATTERN,
  // memory controller side
  REFRESH_REQUEST,
  TRANSFER_REQUEST
);
  // clock and reset
  input  wire        CORE_CLK;
  input  wire        NRST;
  // register port
  input  wire [7:0]  ADDR;
  input  wire [31:0] WDATA;
  input  wire        WR;
  input  wire        RD;
  output reg  [31:0] RDATA;
  // video memory serial side
  output reg         SHIFT_CLOCK_EN;
  output reg         UPPER_LEFT_OE;
  output reg         UPPER_RIGHT_OE;
  output reg         LOWER_LEFT_OE;
  output reg         LOWER_RIGHT_OE;
  output reg         VSYNC;
  output reg  [5:0]  CTRL_PATTERN;
  // memory controller side
  output reg         REFRESH_REQUEST;
  output reg         TRANSFER_REQUEST;

  // frame periods
  localparam [1:0] PER_A = 2'h0;
  localparam [1:0] PER_B = 2'h1;
  localparam [1:0] PER_C = 2'h2;
  localparam [1:0] PER_D = 2'h3;

  // line segment steps: c0, c1, c2, four pixel chunks, c4
  localparam [2:0] ST_C0    = 3'h0;
  localparam [2:0] ST_C1    = 3'h1;
  localparam [2:0] ST_C2    = 3'h2;
  localparam [2:0] ST_PIX0  = 3'h3;
  localparam [2:0] ST_PIX1  = 3'h4;
  localparam [2:0] ST_PIX2  = 3'h5;
  localparam [2:0] ST_PIX3  = 3'h6;
  localparam [2:0] ST_C4    = 3'h7;

  // reset release synchroniser, both active low
  reg        nrst_meta_reg;
  reg        nrst_sync_reg;

  // software registers
  reg        en_reg;
  reg [9:0]  a_lines_reg;
  reg [9:0]  b_lines_reg;
  reg [9:0]  d_lines_reg;

  // sequencer state
  reg [2:0]  step_reg;
  reg [2:0]  step_next;
  reg [7:0]  cnt_reg;
  reg [7:0]  cnt_next;
  reg [1:0]  per_reg;
  reg [1:0]  per_next;
  reg [9:0]  line_reg;
  reg [9:0]  line_next;
  reg        run_reg;

  // refresh guard
  reg [11:0] guard_reg;

  // derived
  wire       seg_done;
  wire       line_done;
  wire       in_pix;
  wire       upper_row;
  wire       right_half;
  wire       refr_slot;
  wire       guard_hit;
  wire [9:0] per_limit;
  wire [2:0] subseg;
  wire [5:0] seg_pat;

  // reload value taken when a segment runs out
  function [7:0] reload_fn;
    input [2:0] st;
    begin
      case (st)
        ST_C0:   reload_fn = `VBT_LD_SHORT;
        ST_C1:   reload_fn = `VBT_LD_SHORT;
        ST_C2:   reload_fn = `VBT_LD_CHUNK;
        ST_PIX0: reload_fn = `VBT_LD_CHUNK;
        ST_PIX1: reload_fn = `VBT_LD_CHUNK;
        ST_PIX2: reload_fn = `VBT_LD_CHUNK;
        ST_PIX3: reload_fn = `VBT_LD_SHORT;
        ST_C4:   reload_fn = `VBT_LD_FIRST;
        default: reload_fn = `VBT_LD_FIRST;
      endcase
    end
  endfunction

  // control pattern for a segment
  function [5:0] pattern_fn;
    input [2:0] st;
    begin
      case (st)
        ST_C0:   pattern_fn = `VBT_PAT_C0;
        ST_C1:   pattern_fn = `VBT_PAT_C1;
        ST_C2:   pattern_fn = `VBT_PAT_C2;
        ST_C4:   pattern_fn = `VBT_PAT_C4;
        default: pattern_fn = `VBT_PAT_C3;
      endcase
    end
  endfunction

  // lines in a period; zero programmed counts act as one line
  function [9:0] limit_fn;
    input [1:0] per;
    input [9:0] a;
    input [9:0] b;
    input [9:0] d;
    begin
      case (per)
        PER_A:   limit_fn = a;
        PER_B:   limit_fn = b;
        PER_C:   limit_fn = `VBT_DISP_LINES;
        default: limit_fn = d;
      endcase
    end
  endfunction

  // pin reset is released through two flops so no register sees the
  // release inside its setup window; assertion still acts at once
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      nrst_meta_reg <= 1'b0;
      nrst_sync_reg <= 1'b0;
    end else begin
      nrst_meta_reg <= 1'b1;
      nrst_sync_reg <= nrst_meta_reg;
    end
  end

  // register writes; run state restarts the frame when enable rises
  always @(posedge CORE_CLK or negedge nrst_sync_reg) begin
    if (!nrst_sync_reg) begin
      en_reg      <= `VBT_CTRL_RST;
      a_lines_reg <= `VBT_A_LINES_RST;
      b_lines_reg <= `VBT_B_LINES_RST;
      d_lines_reg <= `VBT_D_LINES_RST;
    end else if (WR) begin
      case (ADDR)
        `VBT_OFF_CTRL:    en_reg      <= WDATA[`VBT_CTRL_EN_BIT];
        `VBT_OFF_A_LINES: a_lines_reg <= WDATA[9:0];
        `VBT_OFF_B_LINES: b_lines_reg <= WDATA[9:0];
        `VBT_OFF_D_LINES: d_lines_reg <= WDATA[9:0];
        default: ;
      endcase
    end
  end

  // read data stands the cycle after the strobe only; status is a
  // snapshot that may move on before the next read, good for
  // monitoring but not for pacing software against the beam
  always @(posedge CORE_CLK or negedge nrst_sync_reg) begin
    if (!nrst_sync_reg) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        `VBT_OFF_CTRL:    RDATA <= {31'h0, en_reg};
        `VBT_OFF_A_LINES: RDATA <= {22'h0, a_lines_reg};
        `VBT_OFF_B_LINES: RDATA <= {22'h0, b_lines_reg};
        `VBT_OFF_D_LINES: RDATA <= {22'h0, d_lines_reg};
        `VBT_OFF_STATUS:  RDATA <= {11'h0, upper_row, 2'h0, per_reg, 6'h0, line_reg};
        default:          RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  // segment ends when the loop counter has run down
  assign seg_done  = (cnt_reg == 8'h00);
  assign line_done = seg_done && (step_reg == ST_C4);
  assign per_limit = limit_fn(per_reg, a_lines_reg, b_lines_reg, d_lines_reg);

  // line and period stepping; a zero line count reads as one line
  // so that a badly programmed period can never stall the frame
  always @* begin
    step_next = step_reg;
    cnt_next  = cnt_reg - 8'h01;
    per_next  = per_reg;
    line_next = line_reg;
    if (seg_done) begin
      cnt_next  = reload_fn(step_reg);
      step_next = step_reg + 3'h1;
    end
    if (line_done) begin
      // blank periods reuse the same line cycle
      if ((line_reg + 10'h001 >= per_limit) || (per_limit == 10'h000)) begin
        line_next = 10'h000;
        per_next  = per_reg + 2'h1;
      end else begin
        line_next = line_reg + 10'h001;
      end
    end
  end

  // sequencer registers; idle and parked at frame start while disabled
  always @(posedge CORE_CLK or negedge nrst_sync_reg) begin
    if (!nrst_sync_reg) begin
      run_reg  <= 1'b0;
      step_reg <= ST_C0;
      cnt_reg  <= `VBT_LD_FIRST;
      per_reg  <= PER_A;
      line_reg <= 10'h000;
    end else if (!en_reg) begin
      run_reg  <= 1'b0;
      step_reg <= ST_C0;
      cnt_reg  <= `VBT_LD_FIRST;
      per_reg  <= PER_A;
      line_reg <= 10'h000;
    end else begin
      run_reg  <= 1'b1;
      step_reg <= step_next;
      cnt_reg  <= cnt_next;
      per_reg  <= per_next;
      line_reg <= line_next;
    end
  end

  // pixel segment geometry: 4 chunks of 128, 8 subsegments of 64
  assign in_pix     = (step_reg >= ST_PIX0) && (step_reg <= ST_PIX3);
  assign subseg     = {step_reg[1:0] - 2'h3, ~cnt_reg[6]};
  assign right_half = (step_reg == ST_PIX2) || (step_reg == ST_PIX3);
  // first two 128-line loops are the upper half of the screen
  assign upper_row  = (line_reg < `VBT_HALF_LINES);
  assign seg_pat    = pattern_fn(step_reg);

  // even subsegments each open a refresh slot: four per line
  assign refr_slot = run_reg && in_pix && !subseg[0];
  // guard forces a request if the line timing has stalled; while running
  // the widest gap between slots is 143 steps, so once the first slot has passed it fires only when parked
  assign guard_hit = (guard_reg >= `VBT_REFR_GUARD_LAST);

  // refresh guard counts cycles since a request was last raised; the
  // reset value makes up for the cycles the synchroniser holds it
  always @(posedge CORE_CLK or negedge nrst_sync_reg) begin
    if (!nrst_sync_reg) begin
      guard_reg <= `VBT_GUARD_RST;
    end else if (refr_slot || guard_hit) begin
      guard_reg <= 12'h000;
    end else begin
      guard_reg <= guard_reg + 12'h001;
    end
  end

  // registered outputs; blank lines drop the pixel bit, shift clock, quadrant enables and transfer request
  // all come from flops so the far side never sees decode glitches
  // from the step and counter compare
  always @(posedge CORE_CLK or negedge nrst_sync_reg) begin
    if (!nrst_sync_reg) begin
      CTRL_PATTERN     <= 6'h00;
      SHIFT_CLOCK_EN   <= 1'b0;
      UPPER_LEFT_OE    <= 1'b0;
      UPPER_RIGHT_OE   <= 1'b0;
      LOWER_LEFT_OE    <= 1'b0;
      LOWER_RIGHT_OE   <= 1'b0;
      VSYNC            <= 1'b0;
      REFRESH_REQUEST  <= 1'b0;
      TRANSFER_REQUEST <= 1'b0;
    end else if (!run_reg) begin
      CTRL_PATTERN     <= 6'h00;
      SHIFT_CLOCK_EN   <= 1'b0;
      UPPER_LEFT_OE    <= 1'b0;
      UPPER_RIGHT_OE   <= 1'b0;
      LOWER_LEFT_OE    <= 1'b0;
      LOWER_RIGHT_OE   <= 1'b0;
      VSYNC            <= 1'b0;
      // refresh must go on even with the display stopped
      REFRESH_REQUEST  <= guard_hit;
      TRANSFER_REQUEST <= 1'b0;
    end else begin
      // pattern is the same for upper and lower rows
      if (per_reg == PER_C) begin
        CTRL_PATTERN <= seg_pat;
      end else begin
        CTRL_PATTERN <= seg_pat & ~(6'h01 << `VBT_PAT_PIX_BIT);
      end
      // 512 shift clocks: one unbroken burst per display row
      SHIFT_CLOCK_EN <= (per_reg == PER_C) && in_pix;
      // quadrant selection is the only upper/lower difference
      UPPER_LEFT_OE  <= (per_reg == PER_C) && in_pix && upper_row && !right_half;
      UPPER_RIGHT_OE <= (per_reg == PER_C) && in_pix && upper_row && right_half;
      LOWER_LEFT_OE  <= (per_reg == PER_C) && in_pix && !upper_row && !right_half;
      LOWER_RIGHT_OE <= (per_reg == PER_C) && in_pix && !upper_row && right_half;
      VSYNC          <= (per_reg == PER_A);
      // held through each even 64-step subsegment, then withdrawn
      REFRESH_REQUEST <= refr_slot || guard_hit;
      // one load request per display row, in retrace before pixels
      TRANSFER_REQUEST <= (per_reg == PER_C) && (step_reg == ST_C1);
    end
  end

endmodule

// [tb/vbt_line_timing_sva.sv]
// port checker for the line timing block
// assumes it is bound to vbt_line_timing, one clock domain
`timescale 1ns/1ps
module vbt_line_timing_sva (
  // clock and reset
  input wire       CORE_CLK,
  input wire       NRST,
  // timing outputs
  input wire       SHIFT_CLOCK_EN,
  input wire       UPPER_LEFT_OE,
  input wire       UPPER_RIGHT_OE,
  input wire       LOWER_LEFT_OE,
  input wire       LOWER_RIGHT_OE,
  input wire [5:0] CTRL_PATTERN,
  input wire       REFRESH_REQUEST,
  input wire       TRANSFER_REQUEST
);
  reg [9:0]  sc_reg;
  reg [11:0] rc_reg;
  // burst run length and cycles since last refresh
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sc_reg <= 10'h000;
      rc_reg <= 12'h000;
    end else begin
      sc_reg <= SHIFT_CLOCK_EN ? sc_reg + 10'h001 : 10'h000;
      rc_reg <= REFRESH_REQUEST ? 12'h000 : rc_reg + 12'h001;
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // c2 holds, then pixel burst opens after 20 steps
  sequence c2_run;
    (CTRL_PATTERN == 6'h11) [*8];
  endsequence
  sequence pix_go;
    ##20 $rose(SHIFT_CLOCK_EN);
  endsequence
  burst_len_a: assert property ($fell(SHIFT_CLOCK_EN) |-> sc_reg == 10'h200)
    else $error("burst length wrong");
  left_oe_a: assert property (SHIFT_CLOCK_EN && sc_reg < 10'h100 |->
    (UPPER_LEFT_OE ^ LOWER_LEFT_OE) && !UPPER_RIGHT_OE && !LOWER_RIGHT_OE) else $error("left enable wrong");
  right_oe_a: assert property (SHIFT_CLOCK_EN && sc_reg >= 10'h100 |->
    (UPPER_RIGHT_OE ^ LOWER_RIGHT_OE) && !UPPER_LEFT_OE && !LOWER_LEFT_OE) else $error("right enable wrong");
  pix_pat_a: assert property (SHIFT_CLOCK_EN |-> CTRL_PATTERN == 6'h08)
    else $error("pixel pattern wrong");
  refr_slot_a: assert property (SHIFT_CLOCK_EN |-> REFRESH_REQUEST == !sc_reg[6])
    else $error("refresh slot wrong");
  refr_gap_a: assert property (rc_reg <= 12'hc30)
    else $error("refresh gap too long");
  transfer_request_pat_a: assert property (TRANSFER_REQUEST |-> CTRL_PATTERN == 6'h13 && !SHIFT_CLOCK_EN)
    else $error("transfer outside retrace");
  transfer_request_next_a: assert property ($fell(TRANSFER_REQUEST) |-> c2_run and pix_go)
    else $error("c2 segment wrong");
endmodule

bind vbt_line_timing vbt_line_timing_sva u_sva (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .SHIFT_CLOCK_EN(SHIFT_CLOCK_EN), .UPPER_LEFT_OE(UPPER_LEFT_OE), .UPPER_RIGHT_OE(UPPER_RIGHT_OE),
  .LOWER_LEFT_OE(LOWER_LEFT_OE), .LOWER_RIGHT_OE(LOWER_RIGHT_OE), .CTRL_PATTERN(CTRL_PATTERN),
  .REFRESH_REQUEST(REFRESH_REQUEST), .TRANSFER_REQUEST(TRANSFER_REQUEST));

// [tb/vbt_mem_ctrl_model.sv]
// memory controller stand-in serving refresh and transfer requests
// assumes requests are levels on the shared core clock
`timescale 1ns/1ps
module vbt_mem_ctrl_model (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // requests and service tallies
  input wire        refresh_request,
  input wire        transfer_request,
  output reg [15:0] refresh_done,
  output reg [15:0] transfer_done
);
  reg refr_reg;
  reg transfer_request_reg;
  // one service per request edge, nothing kept once withdrawn
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refr_reg <= 1'b0;
      transfer_request_reg <= 1'b0;
      refresh_done <= 16'h0000;
      transfer_done <= 16'h0000;
    end else begin
      refr_reg <= refresh_request;
      transfer_request_reg <= transfer_request;
      if (refresh_request && !refr_reg) refresh_done <= refresh_done + 16'h0001;
      if (transfer_request && !transfer_request_reg) transfer_done <= transfer_done + 16'h0001;
    end
  end
endmodule

// [tb/vbt_line_timing_tb.sv]
// self-checking bench for the line timing block
// assumes the controller model and the bound checker; the lower half lies beyond the run length
`timescale 1ns/1ps
`include "vbt_regs.vh"
module vbt_line_timing_tb;
  reg         CORE_CLK = 1'b0;
  reg         NRST = 1'b0;
  reg  [7:0]  ADDR = 8'h00;
  reg  [31:0] WDATA = 32'h0;
  reg         WR = 1'b0;
  reg         RD = 1'b0;
  wire [31:0] RDATA;
  wire [5:0]  CTRL_PATTERN;
  wire        SHIFT_CLOCK_EN, UPPER_LEFT_OE, UPPER_RIGHT_OE, LOWER_LEFT_OE, LOWER_RIGHT_OE;
  wire        VSYNC, REFRESH_REQUEST, TRANSFER_REQUEST;
  wire [15:0] refr_n, transfer_request_n;
  wire [13:0] line_v = {CTRL_PATTERN, SHIFT_CLOCK_EN, UPPER_LEFT_OE, UPPER_RIGHT_OE, LOWER_LEFT_OE,
                        LOWER_RIGHT_OE, VSYNC, REFRESH_REQUEST, TRANSFER_REQUEST};
  integer     fails = 0;
  integer     n_tests = 0;
  integer     i, n;
  reg  [31:0] d, la;
  reg  [15:0] r0, x0;
  // 200 MHz core clock
  initial begin
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  vbt_line_timing DUT (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SHIFT_CLOCK_EN(SHIFT_CLOCK_EN), .UPPER_LEFT_OE(UPPER_LEFT_OE),
    .UPPER_RIGHT_OE(UPPER_RIGHT_OE), .LOWER_LEFT_OE(LOWER_LEFT_OE), .LOWER_RIGHT_OE(LOWER_RIGHT_OE),
    .VSYNC(VSYNC), .CTRL_PATTERN(CTRL_PATTERN), .REFRESH_REQUEST(REFRESH_REQUEST),
    .TRANSFER_REQUEST(TRANSFER_REQUEST));
  vbt_mem_ctrl_model u_mc (.clk(CORE_CLK), .nrst(NRST), .refresh_request(REFRESH_REQUEST),
    .transfer_request(TRANSFER_REQUEST), .refresh_done(refr_n), .transfer_done(transfer_request_n));
  // expected outputs at step p of a display line, p 0 opening c0
  function [13:0] exp_line(input integer p);
    reg sh;
    begin
      sh = p >= 59 && p < 571;
      exp_line[13:8] = p < 19 ? `VBT_PAT_C0 : p < 39 ? `VBT_PAT_C1 : p < 59 ? `VBT_PAT_C2 :
                       sh ? `VBT_PAT_C3 : `VBT_PAT_C4;
      exp_line[7:0] = {sh, sh && p < 315, sh && p >= 315, 3'b000, sh && ((p - 59) / 64) % 2 == 0,
                       p >= 19 && p < 39};
    end
  endfunction
  task end_of_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bail;
    fails = fails + 1;
    end_of_test;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task chk(input [7:0] a, input [31:0] e);
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    @(negedge CORE_CLK);
    cmp(RDATA, e);
  endtask
  initial begin
    d = $urandom(32'hb745);
    repeat (12) @(posedge CORE_CLK);
    NRST <= 1'b1;
    // the block holds its own reset two more cycles
    repeat (2) @(posedge CORE_CLK);
    // reset values, read-only status, unmapped reads
    chk(`VBT_OFF_CTRL, 32'h0);
    chk(`VBT_OFF_A_LINES, 32'h2);
    chk(`VBT_OFF_B_LINES, 32'h20);
    chk(`VBT_OFF_D_LINES, 32'hb);
    wr(`VBT_OFF_STATUS, 32'hffffffff);
    chk(`VBT_OFF_STATUS, 32'h00100000);
    for (i = 0; i < 4; i = i + 1) chk(8'h14 + 8'($urandom % 236), 32'h0);
    $display("test registers done");
    // guard pulses while idle
    for (n = 0; n < 3200 && REFRESH_REQUEST !== 1'b1; n = n + 1) @(negedge CORE_CLK);
    if (n == 3200) bail;
    @(negedge CORE_CLK);
    for (n = 1; n < 3200 && REFRESH_REQUEST !== 1'b1; n = n + 1) @(negedge CORE_CLK);
    cmp(n, 3120);
    $display("test refresh guard done");
    // short random blank periods, read back
    for (i = 1; i < 4; i = i + 1) begin
      la = $urandom % 3 + 1;
      wr(8'(i * 4), la);
      chk(8'(i * 4), la);
    end
    wr(`VBT_OFF_CTRL, 32'h1);
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    cmp({VSYNC, CTRL_PATTERN}, {1'b1, 6'h33});
    // two whole display lines, step by step
    for (n = 0; n < 5000 && SHIFT_CLOCK_EN !== 1'b1; n = n + 1) @(negedge CORE_CLK);
    if (n == 5000) bail;
    r0 = refr_n;
    x0 = transfer_request_n;
    for (i = 0; i < 1182; i = i + 1) begin
      cmp(line_v, exp_line((59 + i) % 591));
      @(negedge CORE_CLK);
    end
    cmp(refr_n - r0, 8);
    cmp(transfer_request_n - x0, 2);
    chk(`VBT_OFF_STATUS, 32'h00120002);
    $display("test display lines done");
    // disable in c4 so no burst is cut short; parks at period a line 0
    for (n = 0; n < 600 && SHIFT_CLOCK_EN !== 1'b0; n = n + 1) @(negedge CORE_CLK);
    if (n == 600) bail;
    wr(`VBT_OFF_CTRL, 32'h0);
    chk(`VBT_OFF_STATUS, 32'h00100000);
    cmp(line_v, 14'h0000);
    $display("test disable done");
    end_of_test;
  end
endmodule
